// >>> temp_sensor_defines.vh
`ifndef TEMP_SENSOR_DEFINES_VH
`define TEMP_SENSOR_DEFINES_VH

// Clock rate of mclk
`define MCLK_HZ              25000000

// Conversion period of the internal converter, in ms
`define CONV_TIME_MS         300

// Cycles per conversion, longest time rounds down
`define CONV_CYCLES          (`CONV_TIME_MS * (`MCLK_HZ / 1000))

// Width of the conversion timer
`define CONV_CNT_W           23

// Word and transaction geometry
`define WORD_W               16
`define FRAME_BITS           32
`define DRIVEN_BITS          4'he
`define PHASE_BIT            4

// Temperature word fields
`define TEMP_MSB             15
`define TEMP_LSB             3
`define TEMP_W               13
`define TEMP_VALID_POS       2

// Mode control word fields, only the low byte is decoded
`define MODE_LO_MSB          7
`define MODE_LO_LSB          0
`define MODE_LO_W            8
`define MODE_RESET           8'h00
`define MODE_SHUTDOWN        8'hff

// Identification word fields
`define ID_MAKER_MSB         15
`define ID_MAKER_LSB         8
`define ID_ZERO_W            8
// Maker code, value is arbitrary
`define ID_MAKER_CODE        8'ha5

// Reset values
`define TEMP_RESET           13'h0000
`define WORD_RESET           16'h0000
`define BIT_CNT_RESET        5'h00
`define CONV_CNT_RESET       23'h000000

// Least number of write bits that completes a mode write at deselect
`define MODE_MIN_BITS        4'h8

`endif

// >>> temp_sensor_serial_regs.v
// Notes on behaviour
// - Low byte of mode control all ones selects shutdown; upper byte ignored.
// - Any zero in the written low byte selects continuous conversion.
// - After reset the device converts continuously; mode low byte is zero.
// - Mode control is write only; there is no read-back path.
// - Serial port keeps working fully while in shutdown.
// - Temperature word: signed 13-bit value in bits 15:3, MSB first.
// - Bits 1:0 of the temperature word leave the data line released.
// - Bit 2 reads zero until the first conversion completes, then one.
// - Identification word is read only while in shutdown; both words read only.
// - Identification word: maker code high byte, zeros 7:2, bits 1:0 released.
// - Transaction spans chip select low; clock ignored while deselected.
// - First bit driven at select; next bits shift on falling clock edges.
// - After fourteen driven bits the data line is released.
// - First sixteen pulses read a word, next sixteen write mode control.
`timescale 1ns/1ps
`include "temp_sensor_defines.vh"

module temp_sensor_serial_regs #(
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // Serial port pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        sio_in,
  output reg         sio_out,
  output reg         sio_oe,
  // Converter result from the sensing front end
  input  wire [12:0] temperature_value_bits,
  // Status
  output reg         shutdown,
  output reg         result_valid
);

  // Pin synchronisers
  reg        cs_n_m_q;
  reg        cs_n_s_q;
  reg        cs_n_p_q;
  reg        sck_m_q;
  reg        sck_s_q;
  reg        sck_p_q;
  reg        sio_m_q;
  reg        sio_s_q;

  // Serial engine state
  reg  [4:0]  in_cnt_q;
  reg  [4:0]  out_cnt_q;
  reg  [15:0] word_q;
  reg  [15:0] rx_q;
  reg  [7:0]  mode_q;

  // Converter state
  reg  [`CONV_CNT_W-1:0] conv_cnt_q;
  reg  [12:0]            temp_q;
  reg                    valid_q;

  wire        selected;
  wire        sel_start;
  wire        sel_end;
  wire        sck_rise;
  wire        sck_fall;
  wire        is_shutdown;
  wire [4:0]  in_cnt_d;
  wire [4:0]  out_cnt_d;
  wire [15:0] rx_d;
  wire [15:0] temp_word;
  wire [15:0] id_word;
  wire [15:0] read_word;
  wire        conv_done;

  // Two flops on every pin before any logic looks at it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      cs_n_p_q <= 1'b1;
      sck_m_q  <= 1'b0;
      sck_s_q  <= 1'b0;
      sck_p_q  <= 1'b0;
      sio_m_q  <= 1'b0;
      sio_s_q  <= 1'b0;
    end else begin
      cs_n_m_q <= cs_n;
      cs_n_s_q <= cs_n_m_q;
      cs_n_p_q <= cs_n_s_q;
      sck_m_q  <= sck;
      sck_s_q  <= sck_m_q;
      sck_p_q  <= sck_s_q;
      sio_m_q  <= sio_in;
      sio_s_q  <= sio_m_q;
    end
  end

  // Clock edges only count while selected
  assign selected  = ~cs_n_s_q;
  assign sel_start = cs_n_p_q & ~cs_n_s_q;
  assign sel_end   = ~cs_n_p_q & cs_n_s_q;
  assign sck_rise  = selected & ~cs_n_p_q & sck_s_q & ~sck_p_q;
  assign sck_fall  = selected & ~cs_n_p_q & ~sck_s_q & sck_p_q;

  assign in_cnt_d  = in_cnt_q + 5'h01;
  assign out_cnt_d = out_cnt_q + 5'h01;
  assign rx_d      = {rx_q[14:0], sio_s_q};

  assign is_shutdown = (mode_q == `MODE_SHUTDOWN);

  // Read words; bits 1:0 are never driven so their value is moot
  assign temp_word = {temp_q, valid_q, 2'b00};
  assign id_word   = {`ID_MAKER_CODE, {`ID_ZERO_W{1'b0}}};
  assign read_word = is_shutdown ? id_word : temp_word;

  // Rising edges: count pulses and capture the write half
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_cnt_q <= `BIT_CNT_RESET;
      rx_q     <= `WORD_RESET;
    end else if (!selected) begin
      in_cnt_q <= `BIT_CNT_RESET;
      rx_q     <= `WORD_RESET;
    end else if (sck_rise) begin
      in_cnt_q <= in_cnt_d;
      if (in_cnt_q[`PHASE_BIT]) begin
        rx_q <= rx_d;
      end
    end
  end

  // Mode control: only the low byte matters, upper byte discarded
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `MODE_RESET;
    end else if (sck_rise && in_cnt_q == 5'h1f) begin
      mode_q <= rx_d[`MODE_LO_MSB:`MODE_LO_LSB];
    end else if (sel_end && in_cnt_q[`PHASE_BIT]
                 && in_cnt_q[3:0] >= `MODE_MIN_BITS) begin
      // A short write of eight or more bits still takes effect
      mode_q <= rx_q[`MODE_LO_MSB:`MODE_LO_LSB];
    end
  end

  // Falling edges: drive the read half, release for the write half
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_cnt_q <= `BIT_CNT_RESET;
      word_q    <= `WORD_RESET;
      sio_out   <= 1'b0;
      sio_oe    <= 1'b0;
    end else if (!selected) begin
      out_cnt_q <= `BIT_CNT_RESET;
      sio_out   <= 1'b0;
      sio_oe    <= 1'b0;
    end else if (sel_start) begin
      // Snapshot so a conversion finishing mid-read cannot tear the word
      out_cnt_q <= `BIT_CNT_RESET;
      word_q    <= read_word;
      sio_out   <= read_word[`WORD_W-1];
      sio_oe    <= 1'b1;
    end else if (sck_fall) begin
      out_cnt_q <= out_cnt_d;
      if (out_cnt_d == 5'h00) begin
        // Next frame starts: mode written just before decides the word
        word_q  <= read_word;
        sio_out <= read_word[`WORD_W-1];
        sio_oe  <= 1'b1;
      end else if (out_cnt_d[`PHASE_BIT]) begin
        sio_out <= 1'b0;
        sio_oe  <= 1'b0;
      end else if (out_cnt_d[3:0] < `DRIVEN_BITS) begin
        sio_out <= word_q[~out_cnt_d[3:0]];
        sio_oe  <= 1'b1;
      end else begin
        sio_out <= 1'b0;
        sio_oe  <= 1'b0;
      end
    end
  end

  // Converter pacing; the port above never waits on it
  assign conv_done = (conv_cnt_q == CONV_CYCLES - 1);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= `CONV_CNT_RESET;
    end else if (is_shutdown) begin
      // Restart a full period on leaving shutdown
      conv_cnt_q <= `CONV_CNT_RESET;
    end else if (conv_done) begin
      conv_cnt_q <= `CONV_CNT_RESET;
    end else begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      temp_q  <= `TEMP_RESET;
      valid_q <= 1'b0;
    end else if (!is_shutdown && conv_done) begin
      temp_q  <= temperature_value_bits;
      valid_q <= 1'b1;
    end
  end

  // Status outputs straight from flops
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown     <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      shutdown     <= is_shutdown;
      result_valid <= valid_q;
    end
  end

endmodule

// >>> temp_sensor_serial_regs_asserts.sv
`timescale 1ns/1ps
module temp_sensor_serial_regs_asserts #(parameter CONV_CYCLES = 20) (
  // Clock and reset
  input wire        mclk,
  input wire        reset_n,
  // Serial pins
  input wire        cs_n,
  input wire        sck,
  input wire        sio_in,
  input wire        sio_out,
  input wire        sio_oe,
  // Converter and status
  input wire [12:0] temperature_value_bits,
  input wire        shutdown,
  input wire        result_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_idle_off: assert property (cs_n [*5] |-> !sio_oe) else $error("idle drive");
  chk_select_on: assert property ($fell(cs_n) |-> ##[2:5] sio_oe) else $error("no first bit");
  chk_bit_holds: assert property ($rose(sck) && !cs_n |-> $stable(sio_out) [*4]) else $error("bit moved");
  chk_oe_selected: assert property ($rose(sio_oe) |-> !cs_n) else $error("unselected drive");
  chk_mode_write: assert property ($changed(shutdown) |-> !$past(cs_n, 6)) else $error("mode moved");
  chk_reset_mode: assert property ($rose(reset_n) |-> !shutdown [*8]) else $error("mode at reset");
  chk_valid_rise: assert property ($rose(reset_n) |-> !result_valid [*8] ##[1:40] result_valid)
    else $error("valid timing");
  chk_valid_stays: assert property (result_valid |=> result_valid) else $error("valid dropped");
  cover property (shutdown ##1 !shutdown);
  cover property ($rose(result_valid));
  cover property ($fell(sio_oe) && !cs_n);
endmodule
bind temp_sensor_serial_regs temp_sensor_serial_regs_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk (.*);

// >>> spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  // Device output and enable
  input wire  sio_out,
  input wire  sio_oe,
  // Master pins and resolved data line
  output reg  cs_n = 1'b1,
  output reg  sck = 1'b0,
  output wire sio_in
);
  reg        drv_q = 1'b0;
  reg        bit_q = 1'b0;
  reg        float_q = 1'b0;
  reg [15:0] rd;
  reg [15:0] rd_oe;
  integer    j;
  event      done;
  // Released line toggles so a stale bit never passes as data
  assign sio_in = sio_oe ? sio_out : (drv_q ? bit_q : float_q);
  always #20 float_q = ~float_q;
  // Long low phase lets the synchronised output settle before the rise
  task frame(input [15:0] w);
    begin
      cs_n = 1'b0;
      for (j = 1; j <= 32; j = j + 1) begin
        #120;
        drv_q = j > 16;
        bit_q = w[(32 - j) % 16];
        #120 sck = 1'b1;
        if (j <= 16) begin
          rd = {rd[14:0], sio_in};
          rd_oe = {rd_oe[14:0], sio_oe};
        end
        #80 sck = 1'b0;
      end
      #160 cs_n = 1'b1;
      drv_q = 1'b0;
      -> done;
    end
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "temp_sensor_defines.vh"
module testbench;
  reg         mclk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [12:0] temperature_value_bits = 13'h0000;
  reg  [12:0] last_t = 13'h0000;
  reg  [15:0] wr;
  reg  [31:0] rnd;
  reg  [32:0] exp_q;
  reg  [32:0] notes[$];
  reg         sd = 1'b0;
  reg         vexp = 1'b0;
  integer     seed = 32'h8369;
  integer     fails = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     n = 40;
  integer     i;
  wire        cs_n;
  wire        sck;
  wire        sio_in;
  wire        sio_out;
  wire        sio_oe;
  wire        shutdown;
  wire        result_valid;
  temp_sensor_serial_regs #(.CONV_CYCLES(20)) dut (.*);
  spi_master_model m (.*);
  always #20 mclk = ~mclk;
  task complete_run;
    begin
      $display("Checks %0d, errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      complete_run;
    end
  end
  always @(m.done) begin
    exp_q = notes.pop_front();
    checks_done = checks_done + 1;
    if ({shutdown, m.rd_oe, m.rd & 16'hfffc} !== exp_q) begin
      fails = fails + 1;
      $display("Error %0t: got %h want %h", $time, {shutdown, m.rd_oe, m.rd}, exp_q);
    end
    // Every frame outlasts one conversion period, so the flag must be up by its end
    checks_done = checks_done + 1;
    if (result_valid !== 1'b1) begin
      fails = fails + 1;
      $display("Error %0t: result valid flag low after a frame", $time);
    end
  end
  // A short gap after leaving shutdown reads before the restarted timer ends
  task run(input [15:0] w);
    begin
      @(posedge mclk);
      #7;
      notes.push_back({w[7:0] == 8'hff, 16'hfffc, sd ? {`ID_MAKER_CODE, 8'h00} : {last_t, vexp, 2'b00}});
      if (n == 2)
        last_t = temperature_value_bits;
      m.frame(w);
      n = (sd && w[7:0] != 8'hff) ? 2 : 40;
      sd = w[7:0] == 8'hff;
      @(posedge mclk);
      rnd = $random(seed);
      if (n == 40)
        temperature_value_bits <= rnd[12:0];
      repeat (n) @(posedge mclk);
      if (!sd && n == 40) begin
        last_t = temperature_value_bits;
        vexp = 1'b1;
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    run(16'h0000);
    for (i = 0; i < 10; i = i + 1) begin
      wr = $random(seed);
      wr[7:0] = (i[0] | wr[15]) ? 8'hff : 8'hff >> (4'h1 + wr[10:8]);
      run(wr);
    end
    complete_run;
  end
endmodule
